/* hdl/pipe_hist_consts.vh */
// Register offsets, field positions and sizes of the pipe histogram block
`ifndef PIPE_HIST_CONSTS_VH
`define PIPE_HIST_CONSTS_VH

// ==========================================================
// Register byte addresses per pipe
`define CTL_OFS_A         20'h490c0
`define BIN_OFS_A         20'h490c4
`define GUARD_OFS_A       20'h490c8
`define CTL_OFS_B         20'h491c0
`define BIN_OFS_B         20'h491c4
`define GUARD_OFS_B       20'h491c8
`define CTL_OFS_C         20'h492c0
`define BIN_OFS_C         20'h492c4
`define GUARD_OFS_C       20'h492c8

// ==========================================================
// Control register fields
`define CTL_COLLECT_BIT   31
`define CTL_TABLE_EN_BIT  27
`define CTL_HSV_BIT       24
`define CTL_RESTORE_BIT   23
`define CTL_FORMAT_BIT    15
`define CTL_MODE_HI       14
`define CTL_MODE_LO       13
`define CTL_FUNC_BIT      11
`define CTL_IDX_HI        6
`define CTL_WMASK         32'h8980e87f
`define CTL_RESET         32'h00000000

// ==========================================================
// Bin data register fields
`define BIN_BUSY_BIT      31
`define BIN_CNT_HI        23
`define BIN_CORR_HI       9

// ==========================================================
// Guardband register fields
`define GRD_IRQ_EN_BIT    31
`define GRD_EVENT_BIT     30
`define GRD_DELAY_HI      29
`define GRD_DELAY_LO      22
`define GRD_BAND_HI       21
`define GRD_RESET         32'h00400000

// ==========================================================
// Sizes
`define CNT_BINS          32
`define CORR_ENTRIES      33
`define CNT_MAX           24'hffffff

`endif

/* hdl/pipe_histogram_enhancement.v */
// Per-pipe histogram collection and correction table with register access
`timescale 1ns/10ps
`include "pipe_hist_consts.vh"

// How it works
// - Bin data accesses go to the entry picked by function select and index.
// - Bin data updates land at the start of vertical blank.
// - Count function: bit 31 reads busy; set means data invalid.
// - Correction function: bit 31 is reserved, no busy shown.
// - Count bits 23:0 writable only while restore control is set.
// - Count function returns the pixel total of the selected bin.
// - Reported counts refresh when guardband delay is met; invalid until event.
// - Bin pixel counters saturate at maximum instead of wrapping.
// - Correction bits 9:0 are read/write, applied at next vertical blank.
// - Correction entry is a ten-bit value for the bin's lowest point.
// - Control bit 31 enables collection; data valid after an event.
// - Control bit 27 enables correction, starting after next vertical blank.
// - Control bit 11 selects counts (0) or correction values (1).
// - Bin index auto-increments after each bin access unless busy in count function.
// - Guardband interrupt after programmed consecutive exceeding frames.
module pipe_histogram_enhancement #(
    parameter PIPE = 0
) (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire [19:0] regAddr,
    input  wire        regWrite,
    input  wire        regRead,
    input  wire [31:0] regWdata,
    output reg  [31:0] regRdata_ff,
    output reg         regRdValid_ff,
    input  wire [7:0]  pixIn,
    input  wire        pixInValid,
    input  wire        vblankStart,
    output reg  [9:0]  pixOut_ff,
    output reg         pixOutValid_ff,
    output reg         histIrq_ff
);

    // ==========================================================
    // Address decode
    localparam [19:0] CTL_ADDR   = (PIPE == 2) ? `CTL_OFS_C :
                                   (PIPE == 1) ? `CTL_OFS_B : `CTL_OFS_A;
    localparam [19:0] BIN_ADDR   = (PIPE == 2) ? `BIN_OFS_C :
                                   (PIPE == 1) ? `BIN_OFS_B : `BIN_OFS_A;
    localparam [19:0] GUARD_ADDR = (PIPE == 2) ? `GUARD_OFS_C :
                                   (PIPE == 1) ? `GUARD_OFS_B : `GUARD_OFS_A;

    wire hitCtl   = (regAddr == CTL_ADDR);
    wire hitBin   = (regAddr == BIN_ADDR);
    wire hitGuard = (regAddr == GUARD_ADDR);

    // ==========================================================
    // State
    reg [31:0] ctl_ff;
    reg        tableOn_ff;
    reg        countValid_ff;
    reg        grdIrqEn_ff,  pendIrqEn_ff;
    reg [7:0]  grdDelay_ff,  pendDelay_ff;
    reg [21:0] grdBand_ff,   pendBand_ff;
    reg        event_ff;
    reg [7:0]  tripRun_ff;
    reg [23:0] liveCnt  [0:`CNT_BINS-1];
    reg [23:0] repCnt   [0:`CNT_BINS-1];
    reg [23:0] restCnt  [0:`CNT_BINS-1];
    reg [`CNT_BINS-1:0] restPend_ff;
    reg [9:0]  corrPend [0:`CORR_ENTRIES-1];
    reg [9:0]  corrAct  [0:`CORR_ENTRIES-1];

    wire       funcCorr = ctl_ff[`CTL_FUNC_BIT];
    wire [6:0] binIdx   = ctl_ff[`CTL_IDX_HI:0];
    wire       busy     = ~countValid_ff;
    wire       binWr    = regWrite & hitBin;
    wire       binRd    = regRead & hitBin;
    wire       cntRange = (binIdx < `CNT_BINS);
    wire       corRange = (binIdx < `CORR_ENTRIES);
    // In correction function the busy bit is reserved, so it never blocks
    wire       idxStep  = (binWr | binRd) & (funcCorr | ~busy);
    wire [4:0] pixBin   = pixIn[7:3];

    // ==========================================================
    // Guardband comparison per bin
    wire [`CNT_BINS-1:0] exceed;
    wire [23:0] bandScaled = {grdBand_ff, 2'b00};
    genvar g;
    generate
        for (g = 0; g < `CNT_BINS; g = g + 1) begin : gBand
            assign exceed[g] = (liveCnt[g] > repCnt[g]) ?
                               ((liveCnt[g] - repCnt[g]) > bandScaled) :
                               ((repCnt[g] - liveCnt[g]) > bandScaled);
        end
    endgenerate

    wire       frameTrip = ctl_ff[`CTL_COLLECT_BIT] & (|exceed);
    wire [7:0] nxt_tripRun = frameTrip ? tripRun_ff + 8'h01 : 8'h00;
    // Delay of zero is invalid; treated as one so it cannot fire every frame blindly
    wire       delayMet  = vblankStart & frameTrip &
                           (nxt_tripRun >= ((grdDelay_ff == 8'h00) ? 8'h01 : grdDelay_ff));

    // ==========================================================
    // Pixel counters, reported counts and restore staging
    generate
        for (g = 0; g < `CNT_BINS; g = g + 1) begin : gCnt
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    liveCnt[g] <= 24'h000000;
                    repCnt[g]  <= 24'h000000;
                    restCnt[g] <= 24'h000000;
                    restPend_ff[g] <= 1'b0;
                end else begin
                    if (vblankStart) begin
                        liveCnt[g] <= 24'h000000;
                    end else if (ctl_ff[`CTL_COLLECT_BIT] & pixInValid &
                                 (pixBin == g) & (liveCnt[g] != `CNT_MAX)) begin
                        liveCnt[g] <= liveCnt[g] + 24'h000001;
                    end
                    if (vblankStart & restPend_ff[g]) begin
                        repCnt[g] <= restCnt[g];
                    end else if (delayMet) begin
                        repCnt[g] <= liveCnt[g];
                    end
                    if (binWr & ~funcCorr & ctl_ff[`CTL_RESTORE_BIT] & (binIdx == g)) begin
                        restCnt[g]     <= regWdata[`BIN_CNT_HI:0];
                        restPend_ff[g] <= 1'b1;
                    end else if (vblankStart) begin
                        restPend_ff[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Correction table, staged then applied at vertical blank
    generate
        for (g = 0; g < `CORR_ENTRIES; g = g + 1) begin : gCorr
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    corrPend[g] <= 10'h000;
                    corrAct[g]  <= 10'h000;
                end else begin
                    if (binWr & funcCorr & (binIdx == g)) begin
                        corrPend[g] <= regWdata[`BIN_CORR_HI:0];
                    end
                    if (vblankStart) begin
                        corrAct[g] <= corrPend[g];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Control and guardband registers
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_ff        <= `CTL_RESET;
            tableOn_ff    <= 1'b0;
            countValid_ff <= 1'b0;
            grdIrqEn_ff   <= 1'b0;
            pendIrqEn_ff  <= 1'b0;
            grdDelay_ff   <= 8'h01;
            pendDelay_ff  <= 8'h01;
            grdBand_ff    <= 22'h000000;
            pendBand_ff   <= 22'h000000;
            event_ff      <= 1'b0;
            tripRun_ff    <= 8'h00;
        end else begin
            if (regWrite & hitCtl) begin
                ctl_ff <= regWdata & `CTL_WMASK;
            end else if (idxStep) begin
                ctl_ff[`CTL_IDX_HI:0] <= binIdx + 7'h01;
            end
            if (regWrite & hitGuard) begin
                pendIrqEn_ff <= regWdata[`GRD_IRQ_EN_BIT];
                pendDelay_ff <= regWdata[`GRD_DELAY_HI:`GRD_DELAY_LO];
                pendBand_ff  <= regWdata[`GRD_BAND_HI:0];
            end
            if (vblankStart) begin
                tableOn_ff  <= ctl_ff[`CTL_TABLE_EN_BIT];
                grdIrqEn_ff <= pendIrqEn_ff;
                grdDelay_ff <= pendDelay_ff;
                grdBand_ff  <= pendBand_ff;
                tripRun_ff  <= delayMet ? 8'h00 : nxt_tripRun;
            end
            // New event beats a same-cycle write-one-to-clear
            if (delayMet) begin
                event_ff      <= 1'b1;
                countValid_ff <= 1'b1;
            end else if (regWrite & hitGuard & regWdata[`GRD_EVENT_BIT]) begin
                event_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register read path
    reg [31:0] nxt_rdata;
    always @* begin
        nxt_rdata = 32'h00000000;
        if (hitCtl) begin
            nxt_rdata = ctl_ff;
        end else if (hitGuard) begin
            nxt_rdata = {pendIrqEn_ff, event_ff, pendDelay_ff, pendBand_ff};
        end else if (hitBin) begin
            if (funcCorr) begin
                if (corRange) begin
                    nxt_rdata = {22'h000000, corrPend[binIdx[5:0]]};
                end
            end else begin
                nxt_rdata[`BIN_BUSY_BIT] = busy;
                if (cntRange) begin
                    nxt_rdata[`BIN_CNT_HI:0] = repCnt[binIdx[4:0]];
                end
            end
        end
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata_ff   <= 32'h00000000;
            regRdValid_ff <= 1'b0;
        end else begin
            regRdValid_ff <= regRead;
            if (regRead) begin
                regRdata_ff <= nxt_rdata;
            end
        end
    end

    // ==========================================================
    // Pixel correction, direct lookup of the bin's lowest point
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pixOut_ff      <= 10'h000;
            pixOutValid_ff <= 1'b0;
            histIrq_ff     <= 1'b0;
        end else begin
            pixOutValid_ff <= pixInValid;
            if (pixInValid) begin
                pixOut_ff <= tableOn_ff ? corrAct[{1'b0, pixBin}]
                                        : {pixIn, 2'b00};
            end
            histIrq_ff <= grdIrqEn_ff & event_ff;
        end
    end

endmodule // pipe_histogram_enhancement

/* tb/pipe_hist_checker.sv */
// Port assertions for the pipe histogram block
`timescale 1ns/10ps
`include "pipe_hist_consts.vh"
module pipe_hist_checker #(
    parameter PIPE = 0
) (
    input wire        sys_clk,
    input wire        rstn,
    input wire [19:0] regAddr,
    input wire        regRead,
    input wire [31:0] regRdata_ff,
    input wire        regRdValid_ff,
    input wire        pixInValid,
    input wire        vblankStart,
    input wire [9:0]  pixOut_ff,
    input wire        pixOutValid_ff,
    input wire        histIrq_ff
);
    // ====
    // Decode
    localparam [19:0] CTL = (PIPE == 2) ? `CTL_OFS_C :
                            (PIPE == 1) ? `CTL_OFS_B : `CTL_OFS_A;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_ctlRd; regRead && regAddr == CTL; endsequence
    sequence s_binRd; regRead && regAddr == CTL + 20'h4; endsequence
    // Whole 16-byte block of this pipe excluded, not only the three words
    sequence s_offRd; regRead && regAddr[19:4] != CTL[19:4]; endsequence
    // ====
    // Checks
    a_read_answer: assert property (regRead |=> regRdValid_ff)
        else $error("read without answer");
    a_read_quiet: assert property (!regRead |=> !regRdValid_ff)
        else $error("answer without read");
    a_ctl_mask: assert property (s_ctlRd |=> (regRdata_ff & ~`CTL_WMASK) == 32'h0)
        else $error("control reserved bits set");
    a_bin_reserved: assert property (s_binRd |=> regRdata_ff[30:24] == 7'h0)
        else $error("bin reserved bits set");
    a_unmapped_zero: assert property (s_offRd |=> regRdata_ff == 32'h0)
        else $error("unmapped read not zero");
    a_pix_follow: assert property (pixInValid |=> pixOutValid_ff)
        else $error("pixel out missing");
    a_pix_hold: assert property (!pixInValid |=> !pixOutValid_ff && $stable(pixOut_ff))
        else $error("pixel out without pixel");
    a_irq_vblank: assert property ($rose(histIrq_ff) |-> $past(vblankStart, 2))
        else $error("interrupt outside vblank");
endmodule // pipe_hist_checker

bind pipe_histogram_enhancement pipe_hist_checker #(.PIPE(PIPE)) chk_inst (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regRead(regRead),
    .regRdata_ff(regRdata_ff), .regRdValid_ff(regRdValid_ff), .pixInValid(pixInValid),
    .vblankStart(vblankStart), .pixOut_ff(pixOut_ff), .pixOutValid_ff(pixOutValid_ff),
    .histIrq_ff(histIrq_ff));

/* tb/pipe_histogram_enhancement_tb_top.sv */
// Self-checking bench for the pipe histogram block
`timescale 1ns/10ps
`include "pipe_hist_consts.vh"
module pipe_histogram_enhancement_tb_top;
    localparam [19:0] CTL = `CTL_OFS_B;
    localparam [19:0] BIN = `BIN_OFS_B;
    localparam [19:0] GRD = `GUARD_OFS_B;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [19:0] regAddr = 20'h0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata_ff;
    logic        regRdValid_ff;
    logic [7:0]  pixIn = 8'h0;
    logic        pixInValid = 1'b0;
    logic        vblankStart = 1'b0;
    logic [9:0]  pixOut_ff;
    logic        pixOutValid_ff;
    logic        histIrq_ff;
    int          errorCnt = 0;
    int          checkCount = 0;
    logic [9:0]  tableQ [0:32];
    logic [23:0] cntQ [0:31];
    logic [31:0] w;

    pipe_histogram_enhancement #(.PIPE(1)) pipe_histogram_enhancement_inst (
        .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata_ff(regRdata_ff),
        .regRdValid_ff(regRdValid_ff), .pixIn(pixIn), .pixInValid(pixInValid),
        .vblankStart(vblankStart), .pixOut_ff(pixOut_ff), .pixOutValid_ff(pixOutValid_ff),
        .histIrq_ff(histIrq_ff));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // ====
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Table off passes the pixel scaled to ten bits, table on looks up its bin
    function automatic logic [9:0] expPix(input logic [7:0] v, input logic tblOn);
        return tblOn ? tableQ[v[7:3]] : {v, 2'b00};
    endfunction

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        #1 regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge sys_clk);
        #1 regWrite = 1'b0;
    endtask

    // Answer comes exactly one edge after the strobe, so no wait loop
    task automatic rdc(input logic [19:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        #1 regAddr = a;
        regRead = 1'b1;
        @(posedge sys_clk);
        #1 regRead = 1'b0;
        chk({31'h0, regRdValid_ff}, 32'h1);
        chk(regRdata_ff, exp);
    endtask

    task automatic px(input logic [7:0] v, input logic [9:0] exp);
        @(posedge sys_clk);
        #1 pixIn = v;
        pixInValid = 1'b1;
        @(posedge sys_clk);
        #1 pixInValid = 1'b0;
        chk({22'h0, pixOut_ff}, {22'h0, exp});
        chk({31'h0, pixOutValid_ff}, 32'h1);
    endtask

    task automatic vb;
        @(posedge sys_clk);
        #1 vblankStart = 1'b1;
        @(posedge sys_clk);
        #1 vblankStart = 1'b0;
    endtask

    task automatic wrapUp;
        $display("checks=%0d errors=%0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ====
    // Sequence
    initial begin
        w = $urandom(32'h65ac5bee);
        repeat (8) @(posedge sys_clk);
        #1 rstn = 1'b1;
        rdc(CTL, 32'h0);
        rdc(BIN, 32'h80000000);
        rdc(CTL, 32'h0);
        rdc(`CTL_OFS_A, 32'h0);
        wr(CTL, w);
        rdc(CTL, w & `CTL_WMASK);
        wr(CTL, 32'h800);
        for (int i = 0; i < 33; i++) begin
            tableQ[i] = 10'($urandom % 1024);
            wr(BIN, {22'h0, tableQ[i]});
        end
        rdc(CTL, 32'h821);
        wr(CTL, 32'h800);
        for (int i = 0; i < 33; i++) begin
            rdc(BIN, {22'h0, tableQ[i]});
        end
        wr(GRD, 32'h80400000);
        // Collection and table enable set before the first pixel; the table applies only after the next vblank
        wr(CTL, 32'h88000000);
        px(8'h9c, expPix(8'h9c, 1'b0));
        vb;
        for (int i = 0; i < 32; i++) begin
            cntQ[i] = 24'h0;
        end
        // Top bin first, then random pixels through the live table
        for (int i = 0; i < 40; i++) begin
            w = (i == 0) ? 32'hff : $urandom;
            cntQ[w[7:3]]++;
            px(w[7:0], expPix(w[7:0], 1'b1));
        end
        vb;
        chk({31'h0, histIrq_ff}, 32'h1);
        wr(CTL, 32'h88000000);
        for (int i = 0; i < 32; i++) begin
            rdc(BIN, {8'h0, cntQ[i]});
        end
        wr(CTL, 32'h88000000);
        wr(BIN, 32'h00abcdef);
        rdc(CTL, 32'h88000001);
        wr(CTL, 32'h88000000);
        rdc(BIN, {8'h0, cntQ[0]});
        // Collection off; the restored value replaces the count at the next vblank
        wr(CTL, 32'h00800000);
        wr(BIN, 32'h00abcdef);
        wr(CTL, 32'h00800000);
        rdc(BIN, {8'h0, cntQ[0]});
        vb;
        wr(CTL, 32'h00800000);
        rdc(BIN, 32'h00abcdef);
        wr(GRD, 32'h40000000);
        @(posedge sys_clk);
        #1 chk({31'h0, histIrq_ff}, 32'h0);
        wrapUp;
    end
endmodule // pipe_histogram_enhancement_tb_top
